/* File: rtl/dpc_pkg.sv */
package dpc_pkg;

	// ============================================================
	// Task codes of the cyclic parameter area.
	localparam logic [3:0] TC_NONE       = 4'h0;
	localparam logic [3:0] TC_RD_ELEM    = 4'h6;
	localparam logic [3:0] TC_WR_ELEM_W  = 4'h7;
	localparam logic [3:0] TC_WR_ELEM_D  = 4'h8;
	localparam logic [3:0] TC_RSP_WORD   = 4'h4;
	localparam logic [3:0] TC_RSP_DWORD  = 4'h5;
	localparam logic [3:0] TC_RSP_FAIL   = 4'h7;

	// ============================================================
	// Field positions of the request words.
	localparam int TC_MSB   = 15;
	localparam int TC_LSB   = 12;
	localparam int PN_MSB   = 11;
	localparam int GI_MSB   = 15;
	localparam int GI_LSB   = 8;

	// ============================================================
	// Acyclic channel addressing.
	localparam logic [7:0] ACY_SLOT  = 8'h00;
	localparam logic [7:0] ACY_INDEX = 8'h2F;

	// Acyclic answer kinds.
	localparam logic [1:0] ANS_ACK      = 2'h0;
	localparam logic [1:0] ANS_DP_ERR   = 2'h1;
	localparam logic [1:0] ANS_CONFLICT = 2'h2;
	localparam logic [1:0] ANS_RESULT   = 2'h3;

	// Acyclic message kinds.
	localparam logic [1:0] MSG_INIT  = 2'h0;
	localparam logic [1:0] MSG_WRITE = 2'h1;
	localparam logic [1:0] MSG_READ  = 2'h2;
	localparam logic [1:0] MSG_ABORT = 2'h3;

	// ============================================================
	// Cyclic parameter message: four words.
	typedef struct packed {
		logic [15:0] w0;
		logic [15:0] w1;
		logic [15:0] w2;
		logic [15:0] w3;
	} dpc_msg_s;

	// Acyclic request from the master side.
	typedef struct packed {
		logic        valid;
		logic [1:0]  kind;
		logic [7:0]  slot;
		logic [7:0]  index;
		logic        is_read;
		logic        wr_ok;
		logic [15:0] pnum;
		logic [7:0]  group;
		logic        dword;
		logic [31:0] value;
	} dpc_acy_req_s;

	// Parameter store access.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        dword;
		logic [11:0] pnum;
		logic [7:0]  group;
		logic [31:0] wdata;
	} dpc_store_req_s;

	typedef enum logic [1:0] {ST_IDLE, ST_CYC, ST_ACY} dpc_state_e;

endpackage

/* File: rtl/dpc_channel.sv */
`timescale 1ns/1ps
// Overview of operation
// R1 - Element read uses task code 6
// R2 - Group index sits in upper byte word1
// R3 - Word read success answers code 4
// R4 - Word element write uses task code 7
// R5 - Dword success answers code 5, upper first
// R6 - Dword element write uses code 8
// R7 - Master avoids access during inverter reinit
// R8 - Acyclic channel only slot 0 index 47
// R9 - Master opens class 2 channel first
// R10 - Only one open channel at once
// R11 - Master should close channel when done
// R12 - Master starts with write of instructions
// R13 - Valid write gets positive empty acknowledge
// R14 - Invalid write gets DP error answer
// R15 - Read results hold values or error numbers
// R16 - Change results empty unless error occurred
// R17 - Master polls with read requests
// R18 - Busy poll answers state conflict
// R19 - Finished poll answers result and data
// R20 - Group index used only for array tasks
// R21 - Result held until fetched once
module dpc_channel (
	input  wire logic                  clock_in,
	input  wire logic                  reset_n_in,
	input  wire dpc_pkg::dpc_msg_s     cyc_req_in,
	output dpc_pkg::dpc_msg_s          cyc_rsp_out,
	input  wire dpc_pkg::dpc_acy_req_s acy_req_in,
	input  wire logic                  acy_user_in,
	output logic                       acy_ans_valid_out,
	output logic [1:0]                 acy_ans_kind_out,
	output logic [31:0]                acy_ans_data_out,
	output logic                       acy_ans_err_out,
	output logic                       chan_open_out,
	output logic                       chan_user_out,
	output dpc_pkg::dpc_store_req_s    store_req_out,
	input  wire logic                  store_done_in,
	input  wire logic                  store_err_in,
	input  wire logic [15:0]           store_errno_in,
	input  wire logic [31:0]           store_rdata_in
);
	import dpc_pkg::*;

	// ============================================================
	// State of the engine.
	typedef struct packed {
		dpc_state_e     st;
		dpc_msg_s       last_req;
		dpc_msg_s       rsp;
		logic           open;
		logic           user;
		logic           pending;
		logic           ready;
		logic           acy_read;
		logic           ans_v;
		logic [1:0]     ans_k;
		logic [31:0]    ans_d;
		logic           ans_e;
		logic [31:0]    res_d;
		logic           res_e;
		dpc_store_req_s sreq;
	} dpc_state_s;

	dpc_state_s s_r;
	dpc_state_s s_nxt;
	logic [3:0] tc;
	logic       array_task;
	logic       addr_ok;

	assign tc         = cyc_req_in.w0[TC_MSB:TC_LSB];
	assign array_task = (tc == TC_RD_ELEM) || (tc == TC_WR_ELEM_W) || (tc == TC_WR_ELEM_D);
	assign addr_ok    = (acy_req_in.slot == ACY_SLOT) && (acy_req_in.index == ACY_INDEX); // R8

	always_comb begin
		s_nxt            = s_r;
		s_nxt.ans_v      = 1'b0;
		s_nxt.sreq.valid = 1'b0;
		// Acyclic messages are handled in every state.
		if (acy_req_in.valid) begin
			s_nxt.ans_v = 1'b1;
			s_nxt.ans_d = 32'h0000_0000;
			s_nxt.ans_e = 1'b0;
			if (!addr_ok) begin
				s_nxt.ans_k = ANS_DP_ERR; // R8
			end else if (acy_req_in.kind == MSG_INIT) begin
				if (s_r.open && s_r.user != acy_user_in) begin
					s_nxt.ans_k = ANS_DP_ERR; // R10
				end else begin
					s_nxt.open  = 1'b1;
					s_nxt.user  = acy_user_in;
					s_nxt.ans_k = ANS_ACK;
				end
			end else if (!s_r.open || s_r.user != acy_user_in) begin
				s_nxt.ans_k = ANS_DP_ERR; // R10
			end else if (acy_req_in.kind == MSG_ABORT) begin
				s_nxt.open  = 1'b0;
				s_nxt.ans_k = ANS_ACK;
			end else if (acy_req_in.kind == MSG_WRITE) begin
				if (!acy_req_in.wr_ok || s_r.pending || s_r.st != ST_IDLE) begin
					s_nxt.ans_k = ANS_DP_ERR; // R14
				end else begin
					s_nxt.ans_k      = ANS_ACK; // R13
					s_nxt.pending    = 1'b1;
					s_nxt.ready      = 1'b0;
					s_nxt.acy_read   = acy_req_in.is_read;
					s_nxt.st         = ST_ACY;
					s_nxt.sreq.valid = 1'b1;
					s_nxt.sreq.write = !acy_req_in.is_read;
					s_nxt.sreq.dword = acy_req_in.dword;
					s_nxt.sreq.pnum  = acy_req_in.pnum[PN_MSB:0];
					s_nxt.sreq.group = acy_req_in.group;
					s_nxt.sreq.wdata = acy_req_in.value;
				end
			end else if (s_r.pending && !s_r.ready) begin
				s_nxt.ans_k = ANS_CONFLICT; // R18
			end else if (s_r.ready) begin
				s_nxt.ans_k   = ANS_RESULT; // R19
				s_nxt.ans_d   = s_r.res_d;
				s_nxt.ans_e   = s_r.res_e;
				s_nxt.ready   = 1'b0; // R21
				s_nxt.pending = 1'b0;
			end else begin
				s_nxt.ans_k = ANS_CONFLICT; // R21
			end
		end
		case (s_r.st)
			ST_IDLE: begin
				// Cyclic requests are blocked while a class 2 channel is open.
				if (!s_r.open && cyc_req_in != s_r.last_req && array_task && !s_nxt.sreq.valid) begin // R10 R20
					s_nxt.last_req   = cyc_req_in;
					s_nxt.st         = ST_CYC;
					s_nxt.sreq.valid = 1'b1;
					s_nxt.sreq.write = (tc != TC_RD_ELEM); // R1 R4 R6
					s_nxt.sreq.dword = (tc == TC_WR_ELEM_D); // R6
					s_nxt.sreq.pnum  = cyc_req_in.w0[PN_MSB:0]; // R1
					s_nxt.sreq.group = cyc_req_in.w1[GI_MSB:GI_LSB]; // R2
					s_nxt.sreq.wdata = (tc == TC_WR_ELEM_D) ? {cyc_req_in.w2, cyc_req_in.w3} // R6
					                                        : {16'h0000, cyc_req_in.w3}; // R4
				end
			end
			ST_CYC: begin
				if (store_done_in) begin
					s_nxt.st     = ST_IDLE;
					s_nxt.rsp.w1 = {s_r.sreq.group, 8'h00}; // R3
					if (store_err_in) begin
						s_nxt.rsp.w0 = {TC_RSP_FAIL, s_r.sreq.pnum};
						s_nxt.rsp.w2 = 16'h0000;
						s_nxt.rsp.w3 = store_errno_in;
					end else if (s_r.sreq.dword || (!s_r.sreq.write && store_rdata_in[31:16] != 16'h0000)) begin
						s_nxt.rsp.w0 = {TC_RSP_DWORD, s_r.sreq.pnum}; // R5
						s_nxt.rsp.w2 = s_r.sreq.write ? 16'h0000 : store_rdata_in[31:16]; // R5
						s_nxt.rsp.w3 = s_r.sreq.write ? 16'h0000 : store_rdata_in[15:0];
					end else begin
						s_nxt.rsp.w0 = {TC_RSP_WORD, s_r.sreq.pnum}; // R3
						s_nxt.rsp.w2 = 16'h0000;
						s_nxt.rsp.w3 = s_r.sreq.write ? 16'h0000 : store_rdata_in[15:0];
					end
				end
			end
			ST_ACY: begin
				if (store_done_in) begin
					s_nxt.st    = ST_IDLE;
					s_nxt.ready = 1'b1;
					s_nxt.res_e = store_err_in;
					if (s_r.acy_read) begin
						s_nxt.res_d = store_err_in ? {16'h0000, store_errno_in} : store_rdata_in; // R15
					end else begin
						s_nxt.res_d = store_err_in ? {s_r.sreq.pnum[7:0], 8'h00, store_errno_in} // R16
						                           : 32'h0000_0000;
					end
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_r    <= '0;
			s_r.st <= ST_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cyc_rsp_out       = s_r.rsp;
	assign acy_ans_valid_out = s_r.ans_v;
	assign acy_ans_kind_out  = s_r.ans_k;
	assign acy_ans_data_out  = s_r.ans_d;
	assign acy_ans_err_out   = s_r.ans_e;
	assign chan_open_out     = s_r.open;
	assign chan_user_out     = s_r.user;
	assign store_req_out     = s_r.sreq;

	// ============================================================
	// Checks.
	busy_poll_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R18
		acy_req_in.valid && addr_ok && s_r.open && s_r.user == acy_user_in && acy_req_in.kind == MSG_READ
		&& s_r.pending && !s_r.ready |=> acy_ans_kind_out == ANS_CONFLICT)
		else $error("Busy poll did not answer conflict.");
	bad_addr_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R8
		acy_req_in.valid && !addr_ok |=> acy_ans_valid_out && acy_ans_kind_out == ANS_DP_ERR)
		else $error("Wrong slot or index accepted.");
	result_once_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R21
		acy_ans_valid_out && acy_ans_kind_out == ANS_RESULT |-> !s_r.ready)
		else $error("Result still pending after fetch.");
	ack_empty_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R13
		acy_ans_valid_out && acy_ans_kind_out == ANS_ACK |-> acy_ans_data_out == 32'h0000_0000)
		else $error("Acknowledge carried data.");
	word_rsp_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R3
		s_r.st == ST_CYC && store_done_in && !store_err_in && !s_r.sreq.dword && !s_r.sreq.write
		&& store_rdata_in[31:16] == 16'h0000 |=> cyc_rsp_out.w0[15:12] == TC_RSP_WORD && cyc_rsp_out.w2 == 16'h0000)
		else $error("Word answer malformed.");
	dword_rsp_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R5
		s_r.st == ST_CYC && store_done_in && !store_err_in && !s_r.sreq.write && store_rdata_in[31:16] != 16'h0000
		|=> cyc_rsp_out.w0[15:12] == TC_RSP_DWORD && cyc_rsp_out.w2 == $past(store_rdata_in[31:16]))
		else $error("Dword answer malformed.");
	group_echo_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R2
		s_r.st == ST_CYC && store_done_in |=> cyc_rsp_out.w1 == {$past(s_r.sreq.group), 8'h00})
		else $error("Group index not echoed.");
	array_only_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R20
		s_r.st == ST_IDLE && !array_task && !acy_req_in.valid |=> !store_req_out.valid)
		else $error("Non-array task reached the store.");
	single_chan_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R10
		s_r.open && acy_req_in.valid && acy_user_in != s_r.user |=> acy_ans_kind_out == ANS_DP_ERR)
		else $error("Second user was not blocked.");

	// ============================================================
	// Checks of the acyclic channel.
	init_ack_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R10
		acy_req_in.valid && addr_ok && acy_req_in.kind == MSG_INIT && (!s_r.open || s_r.user == acy_user_in)
		|=> acy_ans_kind_out == ANS_ACK && chan_open_out && chan_user_out == $past(acy_user_in))
		else $error("Channel open was refused.");
	close_chan_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R10
		acy_req_in.valid && addr_ok && acy_req_in.kind == MSG_ABORT && s_r.open && s_r.user == acy_user_in
		|=> acy_ans_kind_out == ANS_ACK && !chan_open_out)
		else $error("Channel did not close.");
	closed_refuse_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R10
		acy_req_in.valid && addr_ok && acy_req_in.kind != MSG_INIT && !s_r.open
		|=> acy_ans_kind_out == ANS_DP_ERR)
		else $error("Message accepted on a closed channel.");
	write_ack_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R13
		acy_req_in.valid && addr_ok && s_r.open && s_r.user == acy_user_in && acy_req_in.kind == MSG_WRITE
		&& acy_req_in.wr_ok && !s_r.pending && s_r.st == ST_IDLE
		|=> acy_ans_kind_out == ANS_ACK && store_req_out.valid)
		else $error("Valid write was not acknowledged.");
	bad_write_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R14
		acy_req_in.valid && addr_ok && acy_req_in.kind == MSG_WRITE && !acy_req_in.wr_ok
		|=> acy_ans_kind_out == ANS_DP_ERR)
		else $error("Invalid write was acknowledged.");
	busy_write_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R14
		acy_req_in.valid && addr_ok && acy_req_in.kind == MSG_WRITE && s_r.pending
		|=> acy_ans_kind_out == ANS_DP_ERR)
		else $error("Write accepted while a result was pending.");
	ans_quiet_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R13
		!acy_req_in.valid |=> !acy_ans_valid_out)
		else $error("Answer without a request.");
	result_data_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R19
		acy_req_in.valid && addr_ok && s_r.open && s_r.user == acy_user_in && acy_req_in.kind == MSG_READ
		&& s_r.ready |=> acy_ans_kind_out == ANS_RESULT && acy_ans_data_out == $past(s_r.res_d)
		&& acy_ans_err_out == $past(s_r.res_e))
		else $error("Result answer did not carry the result.");
	no_result_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R21
		acy_req_in.valid && addr_ok && s_r.open && s_r.user == acy_user_in && acy_req_in.kind == MSG_READ
		&& !s_r.ready |=> acy_ans_kind_out == ANS_CONFLICT)
		else $error("Poll without a result did not answer conflict.");
	plain_answer_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R18
		acy_ans_valid_out && acy_ans_kind_out != ANS_RESULT
		|-> acy_ans_data_out == 32'h0000_0000 && !acy_ans_err_out)
		else $error("Answer without result carried data.");
	ready_set_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R19
		s_r.st == ST_ACY && store_done_in |=> s_r.ready && s_r.st == ST_IDLE)
		else $error("Finished instruction did not make a result ready.");
	read_value_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R15
		s_r.st == ST_ACY && store_done_in && s_r.acy_read && !store_err_in
		|=> s_r.res_d == $past(store_rdata_in))
		else $error("Read result lost the value.");
	read_errno_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R15
		s_r.st == ST_ACY && store_done_in && s_r.acy_read && store_err_in
		|=> s_r.res_e && s_r.res_d[15:0] == $past(store_errno_in))
		else $error("Failed read did not hold the error number.");
	change_clean_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R16
		s_r.st == ST_ACY && store_done_in && !s_r.acy_read && !store_err_in
		|=> s_r.res_d == 32'h0000_0000 && !s_r.res_e)
		else $error("Clean change produced result data.");
	change_err_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R16
		s_r.st == ST_ACY && store_done_in && !s_r.acy_read && store_err_in
		|=> s_r.res_e && s_r.res_d[15:0] == $past(store_errno_in))
		else $error("Failed change did not hold the error number.");

	// ============================================================
	// Checks of the cyclic area.
	rd_take_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R1
		s_r.st == ST_IDLE && !s_r.open && !acy_req_in.valid && cyc_req_in != s_r.last_req
		&& tc == TC_RD_ELEM |=> store_req_out.valid && !store_req_out.write
		&& store_req_out.pnum == $past(cyc_req_in.w0[PN_MSB:0]))
		else $error("Element read not passed to the store.");
	word_take_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R4
		s_r.st == ST_IDLE && !s_r.open && !acy_req_in.valid && cyc_req_in != s_r.last_req
		&& tc == TC_WR_ELEM_W |=> store_req_out.valid && store_req_out.write && !store_req_out.dword
		&& store_req_out.wdata == {16'h0000, $past(cyc_req_in.w3)})
		else $error("Word element write malformed.");
	dword_take_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R6
		s_r.st == ST_IDLE && !s_r.open && !acy_req_in.valid && cyc_req_in != s_r.last_req
		&& tc == TC_WR_ELEM_D |=> store_req_out.valid && store_req_out.write && store_req_out.dword
		&& store_req_out.wdata == {$past(cyc_req_in.w2), $past(cyc_req_in.w3)})
		else $error("Dword element write malformed.");
	group_take_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R2
		s_r.st == ST_IDLE && !s_r.open && !acy_req_in.valid && cyc_req_in != s_r.last_req
		&& array_task |=> store_req_out.group == $past(cyc_req_in.w1[GI_MSB:GI_LSB]))
		else $error("Group index not taken from the upper byte.");
	open_block_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R10
		s_r.open && !acy_req_in.valid |=> !store_req_out.valid)
		else $error("Store reached while the channel was open.");
	pnum_echo_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R3
		s_r.st == ST_CYC && store_done_in |=> cyc_rsp_out.w0[PN_MSB:0] == $past(s_r.sreq.pnum))
		else $error("Parameter number not echoed.");
	write_rsp_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R3
		s_r.st == ST_CYC && store_done_in && !store_err_in && s_r.sreq.write
		|=> cyc_rsp_out.w2 == 16'h0000 && cyc_rsp_out.w3 == 16'h0000)
		else $error("Write answer carried a value.");
	dword_low_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R5
		s_r.st == ST_CYC && store_done_in && !store_err_in && !s_r.sreq.write && store_rdata_in[31:16] != 16'h0000
		|=> cyc_rsp_out.w3 == $past(store_rdata_in[15:0]))
		else $error("Dword answer lower half wrong.");
	fail_rsp_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // R15
		s_r.st == ST_CYC && store_done_in && store_err_in
		|=> cyc_rsp_out.w0[TC_MSB:TC_LSB] == TC_RSP_FAIL && cyc_rsp_out.w3 == $past(store_errno_in))
		else $error("Failed access did not report its error number.");
	cv_write_c: cover property (@(posedge clock_in) acy_ans_valid_out && acy_ans_kind_out == ANS_ACK);
	cv_result_c: cover property (@(posedge clock_in) acy_ans_valid_out && acy_ans_kind_out == ANS_RESULT);
	cv_conflict_c: cover property (@(posedge clock_in) acy_ans_valid_out && acy_ans_kind_out == ANS_CONFLICT);
	cv_cyclic_c: cover property (@(posedge clock_in) s_r.st == ST_CYC && store_done_in);
	cv_close_c: cover property (@(posedge clock_in) $fell(chan_open_out));

endmodule

/* File: verif/dpc_store_model.sv */
`timescale 1ns/1ps
module dpc_store_model (
	input  wire logic                    clock_in,
	input  wire logic                    reset_n_in,
	input  wire dpc_pkg::dpc_store_req_s req_in,
	input  wire logic                    slow_in,
	output logic                         done_out,
	output logic                         err_out,
	output logic [15:0]                  errno_out,
	output logic [31:0]                  rdata_out
);
	import dpc_pkg::*;
	logic [3:0]  wait_r;
	logic [11:0] pnum_r;
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wait_r   <= 4'h0;
			pnum_r   <= 12'h000;
			done_out <= 1'b0;
		end else begin
			done_out <= (wait_r == 4'h1);
			if (req_in.valid) begin
				wait_r <= slow_in ? 4'h8 : 4'h2;
				pnum_r <= req_in.pnum;
			end else if (wait_r != 4'h0) begin
				wait_r <= wait_r - 4'h1;
			end
		end
	end
	// Outside the done pulse the error lines show inverted values and the upper data half reads FFFE; the lower half always shows pnum_r.
	assign rdata_out = {16'h0000, 4'h0, pnum_r} ^ {done_out ? {15'h0000, pnum_r[11]} : 16'hFFFE, 16'h0000};
	assign err_out   = (pnum_r == 12'hFFF) ^ !done_out;
	assign errno_out = done_out ? 16'h0011 : 16'hFFEE;
endmodule

/* File: verif/dpc_channel_bench.sv */
`timescale 1ns/1ps
module dpc_channel_bench;
	import dpc_pkg::*;
	logic           clock_in;
	logic           reset_n_in;
	dpc_msg_s       cyc_req;
	dpc_msg_s       cyc_rsp;
	dpc_acy_req_s   acy_req;
	logic           acy_user;
	logic           ans_valid;
	logic [1:0]     ans_kind;
	logic [31:0]    ans_data;
	logic           ans_err;
	logic           chan_open;
	logic           chan_user;
	dpc_store_req_s store_req;
	dpc_store_req_s last_req;
	logic           done;
	logic           s_err;
	logic [15:0]    s_errno;
	logic [31:0]    s_rdata;
	logic           slow;
	logic [31:0]    exp_d [4] = '{32'h0, 32'h000000B4, 32'hFF000011, 32'h00000011};
	int             err_count;
	int             check_count;
	int             n_req;
	int             n;
	dpc_channel u_dpc_channel (.clock_in(clock_in), .reset_n_in(reset_n_in), .cyc_req_in(cyc_req),
		.cyc_rsp_out(cyc_rsp), .acy_req_in(acy_req), .acy_user_in(acy_user), .acy_ans_valid_out(ans_valid),
		.acy_ans_kind_out(ans_kind), .acy_ans_data_out(ans_data), .acy_ans_err_out(ans_err),
		.chan_open_out(chan_open), .chan_user_out(chan_user), .store_req_out(store_req),
		.store_done_in(done), .store_err_in(s_err), .store_errno_in(s_errno), .store_rdata_in(s_rdata));
	dpc_store_model u_dpc_store_model (.clock_in(clock_in), .reset_n_in(reset_n_in), .req_in(store_req),
		.slow_in(slow), .done_out(done), .err_out(s_err), .errno_out(s_errno), .rdata_out(s_rdata));
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		if (store_req.valid === 1'b1)
			n_req++;
	end
	task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			err_count++;
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task wait_for(input logic which);
		for (int i = 0; i < 40; i++) begin
			@(posedge clock_in);
			if ((which ? done : store_req.valid) === 1'b1) begin
				last_req = store_req;
				#1;
				return;
			end
		end
		$display("unexpected wait expected 1 seen 0");
		err_count++;
		report_and_stop();
	endtask
	task cyc(input logic [15:0] w0, w1, w2, w3, input logic [63:0] exp, input logic [1:0] wd, input logic [31:0] wv);
		@(posedge clock_in);
		cyc_req <= {w0, w1, w2, w3};
		wait_for(1'b0);
		chk("store addr", {last_req.pnum, last_req.group}, {w0[11:0], w1[15:8]});
		chk("store kind", {last_req.write, last_req.dword & last_req.write}, wd);
		chk("store data", wd[1] ? last_req.wdata : 32'h0, wv);
		wait_for(1'b1);
		chk("cyc rsp", cyc_rsp, exp);
	endtask
	task acy(input logic [1:0] k, input logic [15:0] si, input logic u, rd, ok, input logic [11:0] pn,
		input logic [1:0] exp);
		@(posedge clock_in);
		acy_req <= '{valid: 1'b1, kind: k, slot: si[15:8], index: si[7:0], is_read: rd, wr_ok: ok,
			pnum: {4'h0, pn}, group: 8'h10, dword: 1'b0, value: 32'h0};
		acy_user <= u;
		@(posedge clock_in);
		acy_req.valid <= 1'b0;
		#1;
		chk("ans valid", ans_valid, 1'b1);
		chk("ans kind", ans_kind, exp);
	endtask
	task test_cyc;
		cyc(16'h60B4, 16'h1000, 16'h0, 16'h0, {16'h40B4, 16'h1000, 16'h0, 16'h00B4}, 2'b00, 0);
		cyc(16'h7001, 16'h0100, 16'h0, 16'h3, {16'h4001, 16'h0100, 32'h0}, 2'b10, 32'h3);
		cyc(16'h8002, 16'h0600, 16'h1, 16'h12C, {16'h5002, 16'h0600, 32'h0}, 2'b11, 32'h1012C);
		cyc(16'h6802, 16'h0600, 16'h0, 16'h0, {16'h5802, 16'h0600, 16'h1, 16'h0802}, 2'b00, 0);
		@(posedge clock_in);
		n = n_req;
		cyc_req <= {16'h23CB, 16'h0000, 32'h1};
		repeat (10) @(posedge clock_in);
		chk("non-array taken", n_req - n, 0);
		$display("cyclic test done");
	endtask
	task test_acy;
		slow <= 1'b1;
		acy(MSG_WRITE, 16'h002F, 0, 1, 1, 12'h0B4, ANS_DP_ERR);
		acy(MSG_INIT, 16'h012F, 0, 0, 0, 0, ANS_DP_ERR);
		acy(MSG_INIT, 16'h0030, 0, 0, 0, 0, ANS_DP_ERR);
		acy(MSG_INIT, 16'h002F, 0, 0, 0, 0, ANS_ACK);
		chk("chan", {chan_open, chan_user}, 2'b10);
		acy(MSG_INIT, 16'h002F, 1, 0, 0, 0, ANS_DP_ERR);
		acy(MSG_WRITE, 16'h002F, 1, 1, 1, 12'h0B4, ANS_DP_ERR);
		acy(MSG_WRITE, 16'h002F, 0, 1, 0, 12'h0B4, ANS_DP_ERR);
		for (int i = 0; i < 4; i++) begin
			acy(MSG_WRITE, 16'h002F, 0, i[0], 1, i[1] ? 12'hFFF : 12'h0B4, ANS_ACK);
			acy(MSG_READ, 16'h002F, 0, 0, 0, 0, ANS_CONFLICT);
			acy(MSG_WRITE, 16'h002F, 0, 1, 1, 12'h0B4, ANS_DP_ERR);
			wait_for(1'b1);
			acy(MSG_READ, 16'h002F, 0, 0, 0, 0, ANS_RESULT);
			chk("ans err", ans_err, i[1]);
			chk("ans data", ans_data, exp_d[i]);
			acy(MSG_READ, 16'h002F, 0, 0, 0, 0, ANS_CONFLICT);
		end
		@(posedge clock_in);
		n = n_req;
		cyc_req <= {16'h6010, 16'h1000, 32'h0};
		repeat (10) @(posedge clock_in);
		chk("cyc while open", n_req - n, 0);
		acy(MSG_ABORT, 16'h002F, 0, 0, 0, 0, ANS_ACK);
		chk("chan closed", chan_open, 1'b0);
		wait_for(1'b0);
		chk("cyc after close", last_req.pnum, 12'h010);
		$display("acyclic test done");
	endtask
	initial begin
		reset_n_in = 1'b0;
		cyc_req = '0;
		acy_req = '0;
		acy_user = 1'b0;
		slow = 1'b0;
		err_count = 0;
		check_count = 0;
		n_req = 0;
		repeat (16) @(posedge clock_in);
		chk("reset outputs", {chan_open, ans_valid, store_req.valid}, 3'b000);
		// No access is made until reset has been released.
		reset_n_in <= 1'b1;
		test_cyc();
		test_acy();
		report_and_stop();
	end
endmodule
